// File: sbs_defines.vh
// Constants for the checked block store with its fast block channels.
// Assumes inclusion by bare name from the design files.
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH
`define SBS_DATA_W      64
`define SBS_CHK_W       8
`define SBS_WORD_W      72
`define SBS_BEAT_W      144
`define SBS_BLK_SHIFT   5
`define SBS_BLK_W       25
`define SBS_LEFT_W      30
`define SBS_CH_W        2
`define SBS_FIFO_DEPTH  2'd2
`define SBS_MAX_BLOCKS  25'h1000000
`define SBS_CODE_LAST   71
`endif

// File: sbs_store.v
// Checked block store answering fast block channel requests from the host.
// Assumes host-side logic on the same clock; host keeps valid data stable until taken.
// What this block does
// (RULE1) Each stored word is 72 bits: 64 data plus 8 check bits.
// (RULE2) Writes compute an 8-bit Hamming checkbyte and store it with the data; a double-error word keeps its received checkbyte.
// (RULE3) Reads recompute the checkbyte and compare with stored one, giving a syndrome.
// (RULE4) Zero syndrome forwards the word unchanged.
// (RULE5) A single flipped data bit is inverted and the corrected word forwarded.
// (RULE6) A double error is flagged uncorrectable and left uncorrected.
// (RULE7) Every detected single or double error emits an error report.
// (RULE8) The store only responds and never starts a transfer itself.
// (RULE9) The host starts and programs every channel transfer.
// (RULE10) Each channel beat carries two 64-bit words with two checkbytes.
// (RULE11) Channel words use the same correct-one, detect-two code as storage.
// (RULE12) Transfers move whole 64-word blocks only, no single-word access.
// (RULE13) Host supplies store address, host memory address and block count.
// (RULE14) Block count accepts up to 16,777,216 blocks.
// (RULE15) Up to four channels, each running independently.
// (RULE16) Double-error words are still forwarded with an uncorrectable flag.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.vh"

module sbs_store #(
   parameter NCH = 4,
   parameter AW  = 12,
   parameter CW  = 32
) (
   // Clock and reset
   input  wire                   clk,
   input  wire                   rst,
   // Transfer commands
   input  wire [NCH-1:0]         cmd_valid,
   input  wire [NCH-1:0]         cmd_write,
   input  wire [NCH*AW-1:0]      cmd_saddr,
   input  wire [NCH*CW-1:0]      cmd_cmaddr,
   input  wire [NCH*25-1:0]      cmd_blocks,
   output wire [NCH-1:0]         cmd_ready,
   output wire [NCH-1:0]         xfer_done,
   // Write beats from host
   input  wire [NCH-1:0]         wr_valid,
   input  wire [NCH*128-1:0]     wr_data,
   input  wire [NCH*16-1:0]      wr_check,
   output wire [NCH-1:0]         wr_ready,
   // Read beats to host
   output wire [NCH-1:0]         rd_valid,
   output wire [NCH*128-1:0]     rd_data,
   output wire [NCH*16-1:0]      rd_check,
   output wire [NCH*2-1:0]       rd_dbe,
   output wire [NCH-1:0]         rd_last,
   output wire [NCH*CW-1:0]      rd_cmaddr,
   input  wire [NCH-1:0]         rd_ready,
   // Error report
   output reg                    err_valid_q,
   output reg  [1:0]             err_sbe_q,
   output reg  [1:0]             err_dbe_q,
   output reg                    err_wr_q,
   output reg  [`SBS_CH_W-1:0]   err_chan_q,
   output reg  [AW-1:0]          err_addr_q
);

   localparam EW = CW + 1 + 2 + 16 + 128;
   localparam LW = `SBS_LEFT_W;

   // Checkbyte over 64 data bits placed at non-power-of-two code positions
   function [7:0] sbs_gen;
      input [63:0] d;
      integer j;
      integer k;
      reg [7:0] c;
      begin
         c = 8'h00;
         k = 0;
         for (j = 3; j <= `SBS_CODE_LAST; j = j + 1) begin
            if ((j & (j - 1)) != 0) begin
               if (d[k])
                  c[6:0] = c[6:0] ^ j[6:0];
               k = k + 1;
            end
         end
         c[7] = ^{d, c[6:0]};
         sbs_gen = c;
      end
   endfunction

   // Syndrome: overall parity of received word, then position bits
   function [7:0] sbs_syn;
      input [63:0] d;
      input [7:0]  c;
      reg   [7:0]  g;
      begin
         g = sbs_gen(d);
         sbs_syn = {^{d, c}, g[6:0] ^ c[6:0]};
      end
   endfunction

   // Flip the data bit named by a single-error syndrome
   function [63:0] sbs_fix;
      input [63:0] d;
      input [7:0]  s;
      integer j;
      integer k;
      reg [63:0] r;
      begin
         r = d;
         k = 0;
         for (j = 3; j <= `SBS_CODE_LAST; j = j + 1) begin
            if ((j & (j - 1)) != 0) begin
               if (s[7] && s[6:0] == j[6:0])
                  r[k] = ~r[k];
               k = k + 1;
            end
         end
         sbs_fix = r;
      end
   endfunction

   // Storage array: one row holds a beat of two checked words
   reg [`SBS_BEAT_W-1:0] mem [0:(1<<(AW-1))-1]; // (RULE1)

   // Channel state
   reg [NCH-1:0]          busy_q;
   reg [NCH-1:0]          wr_q;
   reg [NCH-1:0]          in_full_q;
   reg [NCH-1:0]          cmd_ready_q;
   reg [NCH-1:0]          done_q;
   reg [NCH-1:0]          wr_ready_q;
   reg [NCH-1:0]          rvalid_q;
   reg [AW-1:0]           addr_q [0:NCH-1];
   reg [CW-1:0]           cm_q [0:NCH-1];
   reg [LW-1:0]           left_q [0:NCH-1];
   reg [1:0]              cnt_q [0:NCH-1];
   reg [`SBS_BEAT_W-1:0]  wd_q [0:NCH-1];
   reg [EW-1:0]           ent1_q [0:NCH-1];
   reg [NCH*EW-1:0]       head_q;
   reg [`SBS_CH_W-1:0]    rr_q;

   // Access stage
   reg                    s1_v_q;
   reg                    s1_wr_q;
   reg                    s1_last_q;
   reg [`SBS_CH_W-1:0]    s1_ch_q;
   reg [AW-2:0]           s1_row_q;
   reg [CW-1:0]           s1_cm_q;
   reg [`SBS_BEAT_W-1:0]  wbuf_q;
   reg [`SBS_BEAT_W-1:0]  mrd_q;

   // Next-state terms
   reg [NCH-1:0]          acc;
   reg [NCH-1:0]          wacc;
   reg [NCH-1:0]          pend;
   reg [NCH-1:0]          gnt;
   reg [NCH-1:0]          busy_d;
   reg [NCH-1:0]          full_d;
   reg [NCH-1:0]          done_d;
   reg [NCH-1:0]          req;
   reg [LW-1:0]           left_d [0:NCH-1];
   reg [`SBS_BLK_W-1:0]   blk;
   reg [`SBS_CH_W-1:0]    gch;
   reg                    any_g;
   integer                c;
   integer                m;
   integer                i;
   integer                k;

   always @* begin
      blk = {`SBS_BLK_W{1'b0}};
      for (m = 0; m < NCH; m = m + 1) begin
         pend[m] = s1_v_q & (s1_ch_q == m[`SBS_CH_W-1:0]);
         acc[m]  = cmd_valid[m] & cmd_ready_q[m]; // (RULE9)
         wacc[m] = wr_valid[m] & wr_ready_q[m];
         // Reads reserve a buffer slot before touching memory
         req[m]  = busy_q[m] & (left_q[m] != {LW{1'b0}}) &
                   (wr_q[m] ? in_full_q[m] :
                    ({1'b0, cnt_q[m]} + {2'b00, pend[m]} < {1'b0, `SBS_FIFO_DEPTH})); // (RULE8)
      end
      gnt   = {NCH{1'b0}};
      gch   = rr_q;
      any_g = 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
         k = (rr_q + i) % NCH;
         if (req[k] && !any_g) begin
            gnt[k] = 1'b1;
            gch    = k[`SBS_CH_W-1:0];
            any_g  = 1'b1;
         end
      end
      for (m = 0; m < NCH; m = m + 1) begin
         blk = cmd_blocks[m*25 +: 25];
         if (blk > `SBS_MAX_BLOCKS)
            blk = `SBS_MAX_BLOCKS; // (RULE14)
         left_d[m] = acc[m] ? {blk, {`SBS_BLK_SHIFT{1'b0}}} : // (RULE12)
                     left_q[m] - {{(LW-1){1'b0}}, gnt[m]};
         full_d[m] = wacc[m] | (in_full_q[m] & ~(gnt[m] & wr_q[m]));
         done_d[m] = busy_q[m] & (left_q[m] == {LW{1'b0}}) & (cnt_q[m] == 2'd0) &
                     ~pend[m] & ~in_full_q[m] & ~rvalid_q[m];
         busy_d[m] = acc[m] | (busy_q[m] & ~done_d[m]);
      end
   end

   // Decode of the beat in the access stage, both words in parallel
   wire [`SBS_BEAT_W-1:0] raw   = s1_wr_q ? wbuf_q : mrd_q;
   wire [7:0]  syn0 = sbs_syn(raw[63:0], raw[71:64]); // (RULE3)
   wire [7:0]  syn1 = sbs_syn(raw[135:72], raw[143:136]); // (RULE11)
   wire [63:0] fix0 = sbs_fix(raw[63:0], syn0); // (RULE5)
   wire [63:0] fix1 = sbs_fix(raw[135:72], syn1);
   wire [1:0]  sbe  = {syn1[7], syn0[7]};
   wire [1:0]  dbe  = {~syn1[7] & (|syn1[6:0]), ~syn0[7] & (|syn0[6:0])}; // (RULE6)
   // A double error keeps its received checkbyte so the fault stays visible
   wire [7:0]  oc0  = dbe[0] ? raw[71:64] : sbs_gen(fix0); // (RULE2)
   wire [7:0]  oc1  = dbe[1] ? raw[143:136] : sbs_gen(fix1);
   wire [`SBS_BEAT_W-1:0] fixed = {oc1, fix1, oc0, fix0}; // (RULE10)
   wire [EW-1:0] new_ent = {s1_cm_q, s1_last_q, dbe, oc1, oc0, fix1, fix0}; // (RULE16)
   wire [AW-1:0] gaddr = addr_q[gch];

   // Memory port
   always @(posedge clk) begin
      if (any_g && !wr_q[gch])
         mrd_q <= mem[gaddr[AW-1:1]];
      if (s1_v_q && s1_wr_q)
         mem[s1_row_q] <= fixed; // (RULE2)
   end

   always @(posedge clk) begin
      if (rst) begin
         busy_q      <= {NCH{1'b0}};
         in_full_q   <= {NCH{1'b0}};
         cmd_ready_q <= {NCH{1'b0}};
         done_q      <= {NCH{1'b0}};
         wr_ready_q  <= {NCH{1'b0}};
         rvalid_q    <= {NCH{1'b0}};
         rr_q        <= {`SBS_CH_W{1'b0}};
         s1_v_q      <= 1'b0;
         s1_wr_q     <= 1'b0;
         wr_q        <= {NCH{1'b0}};
         err_valid_q <= 1'b0;
         err_sbe_q   <= 2'b00;
         err_dbe_q   <= 2'b00;
         err_wr_q    <= 1'b0;
         err_chan_q  <= {`SBS_CH_W{1'b0}};
         err_addr_q  <= {AW{1'b0}};
         for (c = 0; c < NCH; c = c + 1) begin
            left_q[c] <= {LW{1'b0}};
            cnt_q[c]  <= 2'd0;
         end
      end else begin
         for (c = 0; c < NCH; c = c + 1) begin // (RULE15)
            busy_q[c]      <= busy_d[c];
            left_q[c]      <= left_d[c];
            in_full_q[c]   <= full_d[c];
            cmd_ready_q[c] <= ~busy_d[c];
            done_q[c]      <= done_d[c];
            wr_ready_q[c]  <= busy_d[c] & (acc[c] ? cmd_write[c] : wr_q[c]) & ~full_d[c] &
                              (left_d[c] > {{(LW-1){1'b0}}, full_d[c]});
            if (acc[c]) begin
               wr_q[c]   <= cmd_write[c];
               addr_q[c] <= cmd_saddr[c*AW +: AW]; // (RULE13)
               cm_q[c]   <= cmd_cmaddr[c*CW +: CW];
            end else if (gnt[c]) begin
               addr_q[c] <= addr_q[c] + {{(AW-2){1'b0}}, 2'b10};
               cm_q[c]   <= cm_q[c] + {{(CW-2){1'b0}}, 2'b10};
            end
            if (wacc[c])
               wd_q[c] <= {wr_check[c*16+8 +: 8], wr_data[c*128+64 +: 64],
                           wr_check[c*16 +: 8], wr_data[c*128 +: 64]};
            // Two-entry read buffer: head drives the port, second entry waits
            if (rvalid_q[c] && rd_ready[c]) begin
               if (cnt_q[c] == 2'd2) begin
                  head_q[c*EW +: EW] <= ent1_q[c];
                  if (pend[c] && !s1_wr_q)
                     ent1_q[c] <= new_ent;
               end else if (pend[c] && !s1_wr_q) begin
                  head_q[c*EW +: EW] <= new_ent; // (RULE4)
               end
            end else if (pend[c] && !s1_wr_q) begin
               if (cnt_q[c] == 2'd0)
                  head_q[c*EW +: EW] <= new_ent;
               else
                  ent1_q[c] <= new_ent;
            end
            cnt_q[c] <= cnt_q[c] + {1'b0, pend[c] & ~s1_wr_q} -
                        {1'b0, rvalid_q[c] & rd_ready[c]};
            rvalid_q[c] <= (cnt_q[c] + {1'b0, pend[c] & ~s1_wr_q} -
                            {1'b0, rvalid_q[c] & rd_ready[c]}) != 2'd0;
         end
         if (any_g)
            rr_q <= gch + {{(`SBS_CH_W-1){1'b0}}, 1'b1};
         s1_v_q    <= any_g;
         s1_wr_q   <= wr_q[gch];
         s1_ch_q   <= gch;
         s1_row_q  <= gaddr[AW-1:1];
         s1_cm_q   <= cm_q[gch];
         s1_last_q <= left_q[gch] == {{(LW-1){1'b0}}, 1'b1};
         wbuf_q    <= wd_q[gch];
         err_valid_q <= s1_v_q & ((|sbe) | (|dbe)); // (RULE7)
         err_sbe_q   <= s1_v_q ? sbe : 2'b00;
         err_dbe_q   <= s1_v_q ? dbe : 2'b00;
         err_wr_q    <= s1_wr_q;
         err_chan_q  <= s1_ch_q;
         err_addr_q  <= {s1_row_q, 1'b0};
      end
   end

   assign cmd_ready = cmd_ready_q;
   assign xfer_done = done_q;
   assign wr_ready  = wr_ready_q;
   assign rd_valid  = rvalid_q;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch_out
         assign rd_data[g*128 +: 128]  = head_q[g*EW +: 128];
         assign rd_check[g*16 +: 16]   = head_q[g*EW+128 +: 16];
         assign rd_dbe[g*2 +: 2]       = head_q[g*EW+144 +: 2];
         assign rd_last[g]             = head_q[g*EW+146];
         assign rd_cmaddr[g*CW +: CW]  = head_q[g*EW+147 +: CW];
      end
   endgenerate

endmodule
`default_nettype wire

// File: sbs_store_chk.sv
// Port checker for the checked block store and its fast block channels.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sbs_store_chk #(parameter NCH = 4, parameter AW = 12, parameter CW = 32) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst,
   // Commands and completion
   input wire logic [NCH-1:0]       cmd_valid,
   input wire logic [NCH-1:0]       cmd_write,
   input wire logic [NCH*25-1:0]    cmd_blocks,
   input wire logic [NCH-1:0]       cmd_ready,
   input wire logic [NCH-1:0]       xfer_done,
   // Beats
   input wire logic [NCH-1:0]       wr_valid,
   input wire logic [NCH-1:0]       wr_ready,
   input wire logic [NCH-1:0]       rd_valid,
   input wire logic [NCH*128-1:0]   rd_data,
   input wire logic [NCH*2-1:0]     rd_dbe,
   input wire logic [NCH-1:0]       rd_last,
   input wire logic [NCH-1:0]       rd_ready,
   // Error report
   input wire logic                 err_valid_q,
   input wire logic [1:0]           err_sbe_q,
   input wire logic [1:0]           err_dbe_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   genvar i;
   for (i = 0; i < NCH; i++) begin : g_ch
      sequence take;
         cmd_valid[i] && cmd_ready[i];
      endsequence
      a_cmd_busy: assert property (take |=> !cmd_ready[i])
         else $error("cmd_ready still high after take");
      a_idle_quiet: assert property (cmd_ready[i] |-> !rd_valid[i] && !wr_ready[i])
         else $error("idle channel moves data");
      a_empty_done: assert property (
         take ##0 (cmd_blocks[i*25+:25] == 0) |-> ##2 xfer_done[i])
         else $error("empty transfer not done in 2");
      a_rd_first: assert property (
         take ##0 (!cmd_write[i] && cmd_blocks[i*25+:25] != 0) |-> ##3 rd_valid[i])
         else $error("first read beat late");
      a_rd_hold: assert property (rd_valid[i] && !rd_ready[i] |=> rd_valid[i]
         && $stable(rd_data[i*128+:128]) && $stable(rd_dbe[i*2+:2]) && $stable(rd_last[i]))
         else $error("read beat lost while stalled");
      a_wr_slot: assert property (wr_valid[i] && wr_ready[i] |=> !wr_ready[i])
         else $error("wr_ready high after take");
      a_last_done: assert property (rd_valid[i] && rd_ready[i] && rd_last[i]
         |-> ##[1:3] xfer_done[i])
         else $error("no done after last beat");
      a_done_reopen: assert property (xfer_done[i] |=> !xfer_done[i] && cmd_ready[i])
         else $error("channel not idle after done");
   end
   a_err_kind: assert property (err_valid_q |-> (err_sbe_q | err_dbe_q) != 0
      && (err_sbe_q & err_dbe_q) == 0)
      else $error("bad error report kind");
endmodule
bind sbs_store sbs_store_chk #(.NCH(NCH), .AW(AW), .CW(CW)) chk_u (.clk, .rst, .cmd_valid,
   .cmd_write, .cmd_blocks, .cmd_ready, .xfer_done, .wr_valid, .wr_ready, .rd_valid, .rd_data,
   .rd_dbe, .rd_last, .rd_ready, .err_valid_q, .err_sbe_q, .err_dbe_q);
`default_nettype wire

// File: sbs_host_model.sv
// Host memory sink pacing the read beats of the fast block channels.
// Assumes the store samples rd_ready on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model #(parameter NCH = 4) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Pacing and read handshake
   input  wire logic           slow,
   output var  logic [NCH-1:0] rd_ready
);
   // Random stalls when slow, always ready otherwise
   always @(negedge clk) begin
      if (rst) begin
         rd_ready <= '0;
      end else begin
         rd_ready <= slow ? NCH'($urandom) : '1;
      end
   end
endmodule
`default_nettype wire

// File: sbs_store_tb_top.sv
// Testbench for the checked block store: block writes with injected errors, stalled reads.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sbs_store_tb_top;
   logic         clk = 0, rst = 1, slow = 0;
   logic [3:0]   cmd_valid = 0, cmd_write = 0, wr_valid = 0;
   logic [47:0]  cmd_saddr = 0;
   logic [127:0] cmd_cmaddr = 0;
   logic [99:0]  cmd_blocks = 0;
   logic [511:0] wr_data = 0;
   logic [63:0]  wr_check = 0;
   wire  [3:0]   cmd_ready, xfer_done, wr_ready, rd_valid, rd_last, rd_ready;
   wire  [511:0] rd_data;
   wire  [63:0]  rd_check;
   wire  [7:0]   rd_dbe;
   wire  [127:0] rd_cmaddr;
   wire          err_valid_q, err_wr_q;
   wire  [1:0]   err_sbe_q, err_dbe_q, err_chan_q;
   wire  [11:0]  err_addr_q;
   logic [178:0] rq[$];
   logic [18:0]  eq[$];
   logic [127:0] mem[32];
   logic [15:0]  chk_mem[32];
   int           mismatches = 0, checked = 0, cyc = 0, dones = 0;

   sbs_store #(.NCH(4), .AW(12), .CW(32)) dut_u (.clk, .rst, .cmd_valid, .cmd_write, .cmd_saddr,
      .cmd_cmaddr, .cmd_blocks, .cmd_ready, .xfer_done, .wr_valid, .wr_data, .wr_check,
      .wr_ready, .rd_valid, .rd_data, .rd_check, .rd_dbe, .rd_last, .rd_cmaddr, .rd_ready,
      .err_valid_q, .err_sbe_q, .err_dbe_q, .err_wr_q, .err_chan_q, .err_addr_q);
   sbs_host_model #(.NCH(4)) host_u (.clk, .rst, .slow, .rd_ready);

   initial forever #4 clk = ~clk;

   function automatic logic [7:0] hc(input logic [63:0] d);
      logic [7:0] c;
      int p, k;
      c = 0;
      k = 0;
      for (p = 1; p < 72; p++) if ((p & (p - 1)) != 0) begin
         if (d[k]) c[6:0] ^= p[6:0];
         k++;
      end
      c[7] = ^{d, c[6:0]};
      return c;
   endfunction

   task automatic chk(input string n, input logic [178:0] e, input logic [178:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic results;
      if (mismatches == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmd(input int c, input logic w, input logic [31:0] cm, input logic [24:0] nb);
      @(negedge clk);
      while (cmd_ready[c] !== 1'b1) @(negedge clk);
      cmd_valid[c] = 1;
      cmd_write[c] = w;
      cmd_saddr[c*12+:12] = 12'h040;
      cmd_cmaddr[c*32+:32] = cm;
      cmd_blocks[c*25+:25] = nb;
      @(negedge clk);
      cmd_valid[c] = 0;
   endtask

   task automatic wbeat(input logic [127:0] d, input logic [15:0] k);
      @(negedge clk);
      wr_valid[0] = 1;
      wr_data[127:0] = d;
      wr_check[15:0] = k;
      while (wr_ready[0] !== 1'b1) @(negedge clk);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         results;
      end
      if (!rst) begin
         dones += $countones(xfer_done);
         for (int c = 0; c < 4; c++) if (rd_valid[c] && rd_ready[c])
            chk("read beat", rq.pop_front(), {rd_data[c*128+:128], rd_check[c*16+:16],
               rd_dbe[c*2+:2], rd_last[c], rd_cmaddr[c*32+:32]});
         if (err_valid_q)
            chk("error report", eq.pop_front(), {err_wr_q, err_sbe_q, err_dbe_q, err_chan_q,
               err_addr_q});
      end
   end

   initial begin
      logic [127:0] d;
      logic [15:0]  k;
      int           b, rc, bit_n;
      void'($urandom(36));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 0;
      for (rc = 0; rc < 4; rc++) cmd(rc, rc[0], 32'h0, 25'h0);
      cmd(0, 1'b1, 32'h0, 25'h1);
      for (b = 0; b < 32; b++) begin
         d = {$urandom, $urandom, $urandom, $urandom};
         k = {hc(d[127:64]), hc(d[63:0])};
         mem[b] = d;
         chk_mem[b] = k;
         bit_n = $urandom_range(63);
         if (b == 2) begin
            d[bit_n] = ~d[bit_n];
            eq.push_back({1'b1, 2'b01, 2'b00, 2'd0, 12'h044});
         end
         if (b == 5) begin
            d[127] = ~d[127];
            d[70] = ~d[70];
            mem[b] = d;
            eq.push_back({1'b1, 2'b00, 2'b10, 2'd0, 12'h04a});
         end
         wbeat(d, k);
      end
      @(negedge clk);
      wr_valid[0] = 0;
      wr_data = ~wr_data;
      while (cmd_ready[0] !== 1'b1) @(negedge clk);
      slow = 1;
      for (rc = 1; rc < 4; rc++) begin
         for (b = 0; b < 32; b++)
            rq.push_back({mem[b], chk_mem[b], b == 5 ? 2'b10 : 2'b00, b == 31,
               32'h100 + 32'(2 * b)});
         eq.push_back({1'b0, 2'b00, 2'b10, 2'(rc), 12'h04a});
         cmd(rc, 1'b0, 32'h100, 25'h1);
         while (cmd_ready[rc] !== 1'b1) @(negedge clk);
      end
      repeat (2) @(negedge clk);
      chk("done pulses", 179'(8), 179'(dones));
      chk("queues left", 179'(0), 179'(rq.size() + eq.size()));
      results;
   end
endmodule
`default_nettype wire
